// File: common/link_cycle_consts.svh
// constants for the link cycle control register bank
`ifndef LINK_CYCLE_CONSTS_SVH
`define LINK_CYCLE_CONSTS_SVH
// register byte offsets
`define LCC_OFS_SET 8'h00
`define LCC_OFS_CLR 8'h04
`define LCC_OFS_TIMER 8'h08
`define LCC_OFS_ISTAT 8'h0c
`define LCC_OFS_IMASK 8'h10
// control word bit positions
`define LCC_BIT_EXT 0
`define LCC_BIT_ORIGIN 1
`define LCC_BIT_TICK 2
`define LCC_BIT_PHY 3
`define LCC_BIT_SID 4
`define LCC_BIT_SYNC 5
`define LCC_CTRL_MASK 32'h0000003f
`define LCC_CTRL_RESET 32'h00000000
// interrupt status bit positions
`define LCC_EV_ROLL 0
`define LCC_EV_OVL 1
`define LCC_EV_CSRX 2
`define LCC_EV_W 3
// timer figures
`define LCC_OFFSET_MAX 12'hbff
`define LCC_PERIODS_PER_SEC 8000
`endif

// File: common/link_cycle_pkg.sv
// types for the link cycle control register bank
package link_cycle_pkg;
  // cycle timer word: seconds, period count, sub-period offset
  typedef struct packed {
    logic [6:0] seconds;
    logic [12:0] period_counter;
    logic [11:0] subperiod_offset;
  } cycle_time_t;
  // software register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// File: design/link_cycle_control_regs.sv
// link control word with set/clear ports, cycle timer and gates
//
// Function
// R1: set-port ones set bits, zeros keep
// R2: clear-port ones clear bits, zeros keep
// R3: both ports read the one control word
// R4: external event advances count, zeroes offset
// R5: external mode offset holds at 3071
// R6: internal mode rolls after 3072 ticks
// R7: no external trigger means bit reads zero
// R8: external select works only with origin enable
// R9: hard reset clears select, soft keeps it
// R10: origin and root emit start on rollover
// R11: origin off loads timer from received starts
// R12: overlong event drops origin, blocks setting
// R13: tick enable counts offset, else stopped
// R14: phy packets stored if accepted and context on
// R15: self-id packets stored only while accepted
// R16: software loads self-id pointer before enabling
// R17: sync requests only while enabled
// R18: timer is offset, period count, seconds
// R19: unused control bits read zero
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "link_cycle_consts.svh"
module link_cycle_control_regs
  import link_cycle_pkg::*;
#(
  parameter bit EXT_TRIG_IMPL = 1'b1,
  parameter int PERIODS_PER_SEC = `LCC_PERIODS_PER_SEC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  // register port
  input wire reg_req_t req,
  output logic [31:0] rdata,
  // pins: tick clock and external period trigger
  input wire logic tick_pin,
  input wire logic ext_event_pin,
  // phy and receiver side
  input wire logic phy_is_root,
  input wire logic overlong_period_event,
  input wire logic rx_start_valid,
  input wire cycle_time_t rx_start_time,
  input wire logic phy_pkt_valid,
  input wire logic selfid_pkt_valid,
  input wire logic async_receive_ctx_enable,
  input wire logic sync_request_want,
  // outputs
  output logic cycle_start_tx,
  output cycle_time_t cycle_start_time,
  output cycle_time_t cycle_timer,
  output logic store_phy_pkt,
  output logic store_selfid_pkt,
  output logic sync_request,
  output logic [31:0] link_config_word,
  output logic irq
);

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [1:0] pin_in; // raw pins
  logic [2:0] sync_r [2]; // three-stage chains
  logic [1:0] stable_r; // agreed level
  logic [1:0] rise_r; // one-cycle rising pulse
  assign pin_in = {ext_event_pin, tick_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      // shift chain; stage 0 feeds only stage 1
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync_r[gi] <= 3'h0;
        end else begin
          sync_r[gi] <= {sync_r[gi][1:0], pin_in[gi]};
        end
      end
      // level accepted once stages 1 and 2 agree
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stable_r[gi] <= 1'b0;
          rise_r[gi] <= 1'b0;
        end else begin
          rise_r[gi] <= 1'b0;
          if (sync_r[gi][1] == sync_r[gi][2]) begin
            stable_r[gi] <= sync_r[gi][2];
            rise_r[gi] <= sync_r[gi][2] & ~stable_r[gi];
          end
        end
      end
    end
  endgenerate

  logic tick_ev; // one tick of the 24.576 MHz clock
  logic ext_ev; // external period event
  assign tick_ev = rise_r[0];
  assign ext_ev = rise_r[1];

  // -------------------------------------------------------------------
  // register decode
  // -------------------------------------------------------------------
  logic wr_set; // write to set port
  logic wr_clr; // write to clear port
  logic wr_istat; // write to interrupt status
  logic wr_imask; // write to interrupt mask
  assign wr_set = req.wr && req.addr == `LCC_OFS_SET;
  assign wr_clr = req.wr && req.addr == `LCC_OFS_CLR;
  assign wr_istat = req.wr && req.addr == `LCC_OFS_ISTAT;
  assign wr_imask = req.wr && req.addr == `LCC_OFS_IMASK;

  // -------------------------------------------------------------------
  // control word
  // -------------------------------------------------------------------
  logic [31:0] ctrl_r; // control word
  logic [31:0] ctrl_nxt; // next control word
  logic [`LCC_EV_W-1:0] istat_r; // sticky events
  logic [`LCC_EV_W-1:0] imask_r; // event mask
  logic [31:0] keep_soft; // bits kept by a soft reset

  assign keep_soft = 32'h1 << `LCC_BIT_EXT;

  // set and clear ports act on one word
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_set) begin
      ctrl_nxt = ctrl_nxt | (req.wdata & `LCC_CTRL_MASK); // R1 R19
    end
    if (wr_clr) begin
      ctrl_nxt = ctrl_nxt & ~(req.wdata & `LCC_CTRL_MASK); // R2
    end
    // overlong drops origin; a standing flag blocks setting it
    if (overlong_period_event || istat_r[`LCC_EV_OVL]) begin
      ctrl_nxt[`LCC_BIT_ORIGIN] = 1'b0; // R12
    end
    if (soft_reset) begin
      ctrl_nxt = ctrl_r & keep_soft; // R9
    end
    if (!EXT_TRIG_IMPL) begin
      ctrl_nxt[`LCC_BIT_EXT] = 1'b0; // R7
    end
  end

  // hard reset clears every bit, select included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `LCC_CTRL_RESET; // R9
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign link_config_word = ctrl_r;

  logic ext_mode; // external trigger in force
  logic origin_en; // timing origin enabled
  assign origin_en = ctrl_r[`LCC_BIT_ORIGIN];
  assign ext_mode = ctrl_r[`LCC_BIT_EXT] & origin_en; // R8

  // -------------------------------------------------------------------
  // cycle timer
  // -------------------------------------------------------------------
  cycle_time_t timer_r; // running timer
  logic advance; // period boundary this cycle
  logic rx_load; // take received start time
  logic last_period; // period count at its last value
  logic [12:0] last_count; // last period count of a second
  assign last_count = 13'(PERIODS_PER_SEC - 1);
  assign last_period = timer_r.period_counter == last_count;
  assign rx_load = rx_start_valid && !origin_en; // R11

  // boundary: external event, or offset wrap in internal mode
  always_comb begin
    if (ext_mode) begin
      advance = ext_ev; // R4
    end else begin
      advance = ctrl_r[`LCC_BIT_TICK] && tick_ev &&
                timer_r.subperiod_offset == `LCC_OFFSET_MAX; // R6
    end
  end

  // offset, period count and seconds update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_r <= '0;
    end else if (rx_load) begin
      timer_r <= rx_start_time; // R11
    end else if (advance) begin
      timer_r.subperiod_offset <= 12'h000; // R4 R6
      if (last_period) begin
        timer_r.period_counter <= 13'h0000;
        timer_r.seconds <= timer_r.seconds + 7'h01;
      end else begin
        timer_r.period_counter <= timer_r.period_counter + 13'h0001;
      end
    end else if (ctrl_r[`LCC_BIT_TICK] && tick_ev) begin
      // in external mode the offset saturates
      if (timer_r.subperiod_offset != `LCC_OFFSET_MAX) begin
        timer_r.subperiod_offset <=
          timer_r.subperiod_offset + 12'h001; // R13 R5
      end
    end
  end

  assign cycle_timer = timer_r; // R18

  // -------------------------------------------------------------------
  // cycle start emission
  // -------------------------------------------------------------------
  logic start_tx_r; // start request pulse
  cycle_time_t start_time_r; // time carried by the start

  // origin and root emit a start at each boundary
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_tx_r <= 1'b0;
      start_time_r <= '0;
    end else begin
      start_tx_r <= advance && origin_en && phy_is_root; // R10
      if (advance) begin
        start_time_r <= timer_r;
      end
    end
  end

  assign cycle_start_tx = start_tx_r;
  assign cycle_start_time = start_time_r;

  // -------------------------------------------------------------------
  // receiver and phy request gates
  // -------------------------------------------------------------------
  logic phy_store_r; // store phy packet
  logic sid_store_r; // store self-id packet
  logic sync_req_r; // sync request to phy

  // each gate is one registered pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phy_store_r <= 1'b0;
      sid_store_r <= 1'b0;
      sync_req_r <= 1'b0;
    end else begin
      phy_store_r <= phy_pkt_valid && ctrl_r[`LCC_BIT_PHY] &&
                     async_receive_ctx_enable; // R14
      sid_store_r <= selfid_pkt_valid && ctrl_r[`LCC_BIT_SID]; // R15
      sync_req_r <= sync_request_want && ctrl_r[`LCC_BIT_SYNC]; // R17
    end
  end

  assign store_phy_pkt = phy_store_r;
  assign store_selfid_pkt = sid_store_r;
  assign sync_request = sync_req_r;

  // -------------------------------------------------------------------
  // interrupts
  // -------------------------------------------------------------------
  logic [`LCC_EV_W-1:0] ev_in; // raw events
  assign ev_in = {rx_load, overlong_period_event, advance};

  // sticky status, write one clears, a new event wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_r <= '0;
    end else begin
      istat_r <= (istat_r & ~(wr_istat ? req.wdata[`LCC_EV_W-1:0] :
                              {`LCC_EV_W{1'b0}})) | ev_in;
    end
  end

  // mask register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      imask_r <= '0;
    end else if (wr_imask) begin
      imask_r <= req.wdata[`LCC_EV_W-1:0];
    end
  end

  assign irq = |(istat_r & imask_r);

  // -------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------
  logic [31:0] rdata_r; // read data, one cycle after strobe

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (req.rd) begin
      case (req.addr)
        `LCC_OFS_SET: rdata_r <= ctrl_r; // R3
        `LCC_OFS_CLR: rdata_r <= ctrl_r; // R3
        `LCC_OFS_TIMER: rdata_r <= timer_r;
        `LCC_OFS_ISTAT: rdata_r <= {29'h0, istat_r};
        `LCC_OFS_IMASK: rdata_r <= {29'h0, imask_r};
        default: rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign rdata = rdata_r;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  localparam logic [31:0] SET_CHK = `LCC_CTRL_MASK & 32'h0000003c;

  a_set_port: assert property (@(posedge clk) disable iff (!rst_n) // R1
    wr_set && !soft_reset |=>
      (ctrl_r & $past(req.wdata) & SET_CHK) == ($past(req.wdata) & SET_CHK))
    else $error("set port did not set bits");

  a_clear_port: assert property (@(posedge clk) disable iff (!rst_n) // R2
    wr_clr && !soft_reset |=>
      (ctrl_r & $past(req.wdata) & `LCC_CTRL_MASK) == 32'h0)
    else $error("clear port did not clear bits");

  a_shared_read: assert property (@(posedge clk) disable iff (!rst_n) // R3
    req.rd && (req.addr == `LCC_OFS_SET || req.addr == `LCC_OFS_CLR)
      |=> rdata == $past(ctrl_r))
    else $error("control read mismatch");

  a_ext_advance: assert property (@(posedge clk) disable iff (!rst_n) // R4
    ext_mode && ext_ev && !rx_load |=> timer_r.subperiod_offset == 12'h0)
    else $error("external event did not zero offset");

  a_ext_hold: assert property (@(posedge clk) disable iff (!rst_n) // R5
    ext_mode && !ext_ev && timer_r.subperiod_offset == `LCC_OFFSET_MAX
      |=> timer_r.subperiod_offset == `LCC_OFFSET_MAX)
    else $error("offset left 3071 without event");

  a_free_roll: assert property (@(posedge clk) disable iff (!rst_n) // R6
    !ext_mode && advance && !rx_load |=>
      timer_r.subperiod_offset == 12'h0 &&
      timer_r.period_counter != $past(timer_r.period_counter))
    else $error("internal rollover wrong");

  a_select_absent: assert property (@(posedge clk) disable iff (!rst_n) // R7
    !EXT_TRIG_IMPL |-> !ctrl_r[`LCC_BIT_EXT])
    else $error("absent select bit reads one");

  a_soft_keep: assert property (@(posedge clk) disable iff (!rst_n) // R9
    soft_reset |=> ctrl_r[`LCC_BIT_EXT] == $past(ctrl_r[`LCC_BIT_EXT]) &&
      (ctrl_r & ~keep_soft) == 32'h0)
    else $error("soft reset handled select wrongly");

  a_start_emit: assert property (@(posedge clk) disable iff (!rst_n) // R10
    advance && origin_en && phy_is_root |=>
      cycle_start_tx && cycle_start_time == $past(timer_r))
    else $error("missing cycle start");

  a_origin_drop: assert property (@(posedge clk) disable iff (!rst_n) // R12
    overlong_period_event |=> !origin_en [*2])
    else $error("origin survived overlong event");

  a_tick_stop: assert property (@(posedge clk) disable iff (!rst_n) // R13
    !ctrl_r[`LCC_BIT_TICK] && !ext_mode && !rx_load |=> $stable(timer_r))
    else $error("timer moved while stopped");

  a_gate_outs: assert property (@(posedge clk) disable iff (!rst_n) // R15
    store_selfid_pkt || sync_request |->
      ($past(ctrl_r[`LCC_BIT_SID]) || !store_selfid_pkt) &&
      ($past(ctrl_r[`LCC_BIT_SYNC]) || !sync_request))
    else $error("gated output while disabled");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (ctrl_r & ~`LCC_CTRL_MASK) == 32'h0)
    else $error("reserved control bit set");

  c_master_start: cover property (@(posedge clk) disable iff (!rst_n)
    cycle_start_tx);
  c_ext_hold: cover property (@(posedge clk) disable iff (!rst_n)
    ext_mode && timer_r.subperiod_offset == `LCC_OFFSET_MAX ##1 ext_ev);
  c_overlong: cover property (@(posedge clk) disable iff (!rst_n)
    overlong_period_event && origin_en);
  c_rx_sync: cover property (@(posedge clk) disable iff (!rst_n)
    rx_load);

endmodule

// File: sim/link_cycle_control_regs_bench.sv
// self-checking bench for the link cycle control register bank
`timescale 1ns/1ns
`include "link_cycle_consts.svh"
module link_cycle_control_regs_bench
  import link_cycle_pkg::*;
;
  // clock, resets and bench-driven inputs
  logic clk, rst_n, soft_reset, overlong_period_event;
  logic async_receive_ctx_enable, sync_request_want;
  reg_req_t req;
  // far-side pins
  logic tick_pin, ext_event_pin, phy_is_root, rx_start_valid;
  logic phy_pkt_valid, selfid_pkt_valid;
  cycle_time_t rx_start_time;
  // phy model command handshake
  logic cmd_valid, cmd_done;
  logic [2:0] cmd_op;
  logic [31:0] cmd_arg;
  // design outputs
  logic [31:0] rdata, link_config_word;
  cycle_time_t cycle_start_time, cycle_timer, last_start;
  logic cycle_start_tx, store_phy_pkt, store_selfid_pkt;
  logic sync_request, irq;
  // bookkeeping
  int err_total, checks_done, starts;

  link_cycle_control_regs #(.PERIODS_PER_SEC(4)) uut (
    .clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .req(req),
    .rdata(rdata), .tick_pin(tick_pin), .ext_event_pin(ext_event_pin),
    .phy_is_root(phy_is_root),
    .overlong_period_event(overlong_period_event),
    .rx_start_valid(rx_start_valid), .rx_start_time(rx_start_time),
    .phy_pkt_valid(phy_pkt_valid), .selfid_pkt_valid(selfid_pkt_valid),
    .async_receive_ctx_enable(async_receive_ctx_enable),
    .sync_request_want(sync_request_want),
    .cycle_start_tx(cycle_start_tx), .cycle_start_time(cycle_start_time),
    .cycle_timer(cycle_timer), .store_phy_pkt(store_phy_pkt),
    .store_selfid_pkt(store_selfid_pkt), .sync_request(sync_request),
    .link_config_word(link_config_word), .irq(irq)
  );
  phy_model phy (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_arg(cmd_arg), .cmd_done(cmd_done),
    .tick_pin(tick_pin), .ext_event_pin(ext_event_pin),
    .phy_is_root(phy_is_root), .rx_start_valid(rx_start_valid),
    .rx_start_time(rx_start_time), .phy_pkt_valid(phy_pkt_valid),
    .selfid_pkt_valid(selfid_pkt_valid)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count emitted cycle starts away from the launching edge
  always @(negedge clk) begin
    if (cycle_start_tx === 1'b1) begin
      starts++;
      last_start = cycle_start_time;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e, "read data");
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // side inputs: {receive context enable, overlong event, soft reset}
  task automatic side_set(input logic [2:0] v);
    @(posedge clk);
    {async_receive_ctx_enable, overlong_period_event, soft_reset} <= v;
    #1;
  endtask
  // one command to the phy model, held until it reports done
  task automatic phy_do(input logic [2:0] op, input logic [31:0] arg);
    @(posedge clk);
    cmd_op <= op;
    cmd_arg <= arg;
    cmd_valid <= 1'b1;
    @(cmd_done);
    cmd_valid <= 1'b0;
  endtask
  task automatic sync_try(input logic e);
    @(posedge clk);
    sync_request_want <= 1'b1;
    @(posedge clk);
    sync_request_want <= 1'b0;
    #1 chk(sync_request, e, "sync request");
  endtask
  function automatic cycle_time_t tm(input logic [6:0] s,
      input logic [12:0] c, input logic [11:0] o);
    tm = {s, c, o};
  endfunction
  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well beyond the two long tick runs
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    req = '0;
    overlong_period_event = 1'b0;
    async_receive_ctx_enable = 1'b0;
    sync_request_want = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_arg = 32'h0;
    err_total = 0;
    checks_done = 0;
    starts = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(link_config_word, 32'h0, "hard reset word");
    // set and clear ports over one word
    rd(`LCC_OFS_SET, 32'h0);
    wr(`LCC_OFS_SET, 32'hffffffff);
    rd(`LCC_OFS_CLR, 32'h3f);
    wr(`LCC_OFS_CLR, 32'h2a);
    rd(`LCC_OFS_SET, 32'h15);
    side_set(3'b001);
    side_set(3'b000);
    chk(link_config_word, 32'h1, "soft reset keeps select");
    wr(`LCC_OFS_CLR, 32'h1);
    rd(8'h20, 32'h0);
    // receive and request gates; no self-id pointer exists here
    side_set(3'b100);
    wr(`LCC_OFS_SET, 32'h38);
    phy_do(3'h4, 32'h0);
    #1 chk(store_phy_pkt, 1'b1, "phy packet kept");
    phy_do(3'h4, 32'h1);
    #1 chk(store_selfid_pkt, 1'b1, "self-id kept");
    sync_try(1'b1);
    wr(`LCC_OFS_CLR, 32'h30);
    phy_do(3'h4, 32'h1);
    #1 chk(store_selfid_pkt, 1'b0, "self-id dropped");
    sync_try(1'b0);
    side_set(3'b000);
    phy_do(3'h4, 32'h0);
    #1 chk(store_phy_pkt, 1'b0, "context off");
    // timer load, internal roll, stop
    phy_do(3'h3, tm(7'h01, 13'h0002, 12'hbb8));
    #1 chk(cycle_timer, tm(7'h01, 13'h0002, 12'hbb8), "load");
    wr(`LCC_OFS_SET, 32'h4);
    phy_do(3'h0, 32'd100);
    settle(8);
    chk(cycle_timer, tm(7'h01, 13'h0003, 12'h01c), "roll");
    wr(`LCC_OFS_CLR, 32'h4);
    phy_do(3'h0, 32'd5);
    settle(8);
    chk(cycle_timer, tm(7'h01, 13'h0003, 12'h01c), "stopped");
    // origin with root emits a start at the rollover
    phy_do(3'h2, 32'h1);
    wr(`LCC_OFS_SET, 32'h6);
    phy_do(3'h0, 32'd3044);
    settle(8);
    chk(cycle_timer, tm(7'h02, 13'h0000, 12'h000), "carry");
    chk(starts, 32'h1, "start count");
    chk(last_start, tm(7'h01, 13'h0003, 12'hbff), "start time");
    // external trigger mode
    wr(`LCC_OFS_SET, 32'h1);
    phy_do(3'h0, 32'd3100);
    settle(8);
    chk(cycle_timer, tm(7'h02, 13'h0000, 12'hbff), "held");
    phy_do(3'h1, 32'h0);
    settle(8);
    chk(cycle_timer, tm(7'h02, 13'h0001, 12'h000), "ext step");
    chk(starts, 32'h2, "ext start");
    wr(`LCC_OFS_CLR, 32'h2);
    phy_do(3'h1, 32'h0);
    settle(8);
    chk(cycle_timer, tm(7'h02, 13'h0001, 12'h000), "ignored");
    // overlong event drops and blocks the origin bit
    wr(`LCC_OFS_SET, 32'h2);
    side_set(3'b010);
    side_set(3'b000);
    settle(1);
    chk(link_config_word, 32'hd, "origin dropped");
    wr(`LCC_OFS_SET, 32'h2);
    rd(`LCC_OFS_SET, 32'hd);
    rd(`LCC_OFS_ISTAT, 32'h7);
    chk(irq, 1'b0, "masked");
    wr(`LCC_OFS_IMASK, 32'h2);
    chk(irq, 1'b1, "irq up");
    wr(`LCC_OFS_ISTAT, 32'h2);
    chk(irq, 1'b0, "irq cleared");
    wr(`LCC_OFS_SET, 32'h2);
    rd(`LCC_OFS_CLR, 32'hf);
    // hard reset in mid-run clears the select bit as well
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(link_config_word, 32'h0, "hard reset clears select");
    tally_and_finish;
  end
endmodule

// File: sim/phy_model.sv
// far-side model: phy pins, tick clock and packet pulses
`timescale 1ns/1ns
module phy_model
  import link_cycle_pkg::*;
(
  // clock
  input wire logic clk,
  // commands from the bench, one at a time
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [31:0] cmd_arg,
  output logic cmd_done,
  // pins and pulses toward the link
  output logic tick_pin,
  output logic ext_event_pin,
  output logic phy_is_root,
  output logic rx_start_valid,
  output cycle_time_t rx_start_time,
  output logic phy_pkt_valid,
  output logic selfid_pkt_valid
);
  // flip one pin; both pins idle low between pulses
  task automatic pin_flip(input bit ext);
    if (ext) begin
      ext_event_pin <= ~ext_event_pin;
    end else begin
      tick_pin <= ~tick_pin;
    end
  endtask
  // pin pulse 3 clocks high, 3 low, long enough for the link filter
  task automatic pin_pulse(input bit ext);
    repeat (3) @(posedge clk);
    pin_flip(ext);
    repeat (3) @(posedge clk);
    pin_flip(ext);
  endtask
  // everything idle at time zero, then serve bench commands:
  // 0 ticks, 1 external event, 2 root level, 3 cycle start, 4 packet
  initial begin
    cmd_done = 1'b0;
    tick_pin = 1'b0;
    ext_event_pin = 1'b0;
    phy_is_root = 1'b0;
    rx_start_valid = 1'b0;
    rx_start_time = '0;
    phy_pkt_valid = 1'b0;
    selfid_pkt_valid = 1'b0;
    forever begin
      @(posedge clk);
      if (cmd_valid === 1'b1) begin
        case (cmd_op)
          // tick clock runs only while asked for
          3'h0: repeat (cmd_arg) pin_pulse(1'b0);
          3'h1: pin_pulse(1'b1);
          3'h2: phy_is_root <= cmd_arg[0];
          3'h3: begin
            // received cycle start; the time word is garbled after it
            rx_start_valid <= ~rx_start_valid;
            rx_start_time <= cmd_arg;
            @(posedge clk);
            rx_start_valid <= ~rx_start_valid;
            rx_start_time <= ~cmd_arg;
          end
          default: begin
            // one incoming packet: arg bit 0 picks self-id over phy
            selfid_pkt_valid <= cmd_arg[0];
            phy_pkt_valid <= ~cmd_arg[0];
            @(posedge clk);
            selfid_pkt_valid <= 1'b0;
            phy_pkt_valid <= 1'b0;
          end
        endcase
        // toggle tells the bench the command is finished
        cmd_done <= ~cmd_done;
      end
    end
  end
endmodule
